// [rtl/acl_controller.sv]
// controller end of the time-division codec audio link
module acl_controller #(
   parameter int LINK_DIV_HALF = acl_pkg::LINK_DIV_HALF_DEFAULT
) (
   // system clock domain
   input wire logic CLK,
   input wire logic RST,
   input wire logic CE,
   // link source clock, 2 * LINK_DIV_HALF times the bit clock rate
   input wire logic LINK_CLK,
   // control
   input wire logic RUN_ENABLE,
   input wire logic CODEC_RESET_REQ,
   input wire logic TAG_LOAD,
   input wire logic [acl_pkg::TAG_W-1:0] STREAM_TAG,
   // outbound frame buffer write
   input wire logic TX_WRITE,
   input wire logic [acl_pkg::TX_ADDR_W-1:0] TX_ADDR,
   input wire logic [acl_pkg::TX_BYTE_W-1:0] TX_DATA,
   // inbound words, one lane per codec line
   output logic [acl_pkg::LINES-1:0] RX_VALID,
   output logic [acl_pkg::LINES*acl_pkg::RX_WORD_W-1:0] RX_DATA,
   output logic [acl_pkg::LINES-1:0] RX_FIRST,
   output logic FRAME_TICK,
   // codec pins
   output logic CODEC_RESET_N,
   output logic FRAME_SYNC,
   output logic LINK_BIT_CLOCK,
   output logic SERIAL_OUT_TO_CODECS,
   input wire logic [acl_pkg::LINES-1:0] SERIAL_IN_FROM_CODECS
);
   import acl_pkg::*;

   localparam int DIV_W = (LINK_DIV_HALF > 1) ? $clog2(LINK_DIV_HALF) : 1;
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(LINK_DIV_HALF - 1);

   // ==========================================================
   // system domain control
   logic run_req;
   logic [TAG_W-1:0] tag_hold;
   logic tag_toggle;

   always_ff @(posedge CLK) begin
      if (RST) begin
         CODEC_RESET_N <= 1'b0;
      end else if (CE) begin
         CODEC_RESET_N <= ~CODEC_RESET_REQ;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         run_req <= 1'b0;
      end else if (CE) begin
         run_req <= RUN_ENABLE & ~CODEC_RESET_REQ;
      end
   end

   // the holding register stays still while the link copies it
   always_ff @(posedge CLK) begin
      if (RST) begin
         tag_hold <= TAG_RESET;
         tag_toggle <= 1'b0;
      end else if (CE && TAG_LOAD) begin
         tag_hold <= STREAM_TAG;
         tag_toggle <= ~tag_toggle;
      end
   end

   // ==========================================================
   // link domain reset and crossings into it
   logic lrst_meta;
   logic lrst;
   logic run_meta;
   logic run_link;
   logic treq_meta;
   logic treq_s;
   logic treq_d;
   logic [TAG_W-1:0] tag_link;

   always_ff @(posedge LINK_CLK) begin
      lrst_meta <= RST;
      lrst <= lrst_meta;
   end

   always_ff @(posedge LINK_CLK) begin
      if (lrst) begin
         run_meta <= 1'b0;
         run_link <= 1'b0;
      end else begin
         run_meta <= run_req;
         run_link <= run_meta;
      end
   end

   always_ff @(posedge LINK_CLK) begin
      if (lrst) begin
         treq_meta <= 1'b0;
         treq_s <= 1'b0;
         treq_d <= 1'b0;
         tag_link <= TAG_RESET;
      end else begin
         treq_meta <= tag_toggle;
         treq_s <= treq_meta;
         treq_d <= treq_s;
         if (treq_s != treq_d) begin
            tag_link <= tag_hold;
         end
      end
   end

   // ==========================================================
   // bit clock divider and half-bit counter
   logic [DIV_W-1:0] div_cnt;
   logic advance;
   logic [HALF_W-1:0] half;
   logic [HALF_W-1:0] next_half;
   logic [BIT_W-1:0] bit_idx;
   logic frame_wrap;

   assign advance = (div_cnt == DIV_LAST);
   assign bit_idx = half[HALF_W-1:1];
   assign frame_wrap = advance && (half == LAST_HALF);

   always_ff @(posedge LINK_CLK) begin
      if (lrst || advance) begin
         div_cnt <= '0;
      end else begin
         div_cnt <= div_cnt + 1'b1;
      end
   end

   // one frame is 1000 half bits, 500 bit clocks at 24 MHz, so frames come at 48 kHz
   always_comb begin
      next_half = half;
      if (advance) begin
         next_half = (half == LAST_HALF) ? '0 : half + 1'b1;
      end
   end

   always_ff @(posedge LINK_CLK) begin
      if (lrst) begin
         half <= '0;
      end else begin
         half <= next_half;
      end
   end

   // ==========================================================
   // frame state
   acl_link_state_type state;
   acl_link_state_type next_state;
   logic next_run;
   logic [TAG_W-1:0] frame_tag;

   // decided before the marker starts, so marker and next frame agree
   always_ff @(posedge LINK_CLK) begin
      if (lrst) begin
         next_run <= 1'b0;
      end else if (advance && half == MARK_DECIDE_HALF) begin
         next_run <= run_link;
      end
   end

   always_comb begin
      next_state = state;
      case (state)
         LS_RESET: begin
            if (frame_wrap) begin
               next_state = LS_IDLE;
            end
         end
         LS_IDLE: begin
            if (frame_wrap && next_run) begin
               next_state = LS_RUN;
            end
         end
         LS_RUN: begin
            if (frame_wrap && !next_run) begin
               next_state = LS_IDLE;
            end
         end
         default: begin
            next_state = LS_RESET;
         end
      endcase
   end

   always_ff @(posedge LINK_CLK) begin
      if (lrst) begin
         state <= LS_RESET;
      end else begin
         state <= next_state;
      end
   end

   // the stream number changes only at a frame boundary
   always_ff @(posedge LINK_CLK) begin
      if (lrst) begin
         frame_tag <= TAG_RESET;
      end else if (frame_wrap) begin
         frame_tag <= tag_link;
      end
   end

   // ==========================================================
   // outbound pins
   logic [TX_BYTE_W-1:0] tx_rd;
   logic mark_on;

   acl_tx_ram #(
      .WIDTH(TX_BYTE_W),
      .DEPTH(TX_DEPTH),
      .ADDR_W(TX_ADDR_W)
   ) u_tx_ram (
      .wr_clk(CLK),
      .wr_en(TX_WRITE & CE),
      .wr_addr(TX_ADDR),
      .wr_data(TX_DATA),
      .rd_clk(LINK_CLK),
      .rd_addr(next_half[HALF_W-1:3]),
      .rd_data(tx_rd)
   );

   assign mark_on = next_run && (state != LS_RESET);

   // pins are one half bit behind the counter, matching the buffer read latency
   always_ff @(posedge LINK_CLK) begin
      if (lrst) begin
         LINK_BIT_CLOCK <= 1'b0;
         FRAME_SYNC <= 1'b0;
         SERIAL_OUT_TO_CODECS <= 1'b0;
      end else if (advance) begin
         LINK_BIT_CLOCK <= ~half[0];
         FRAME_SYNC <= acl_sync_level(bit_idx, frame_tag, state == LS_RUN, mark_on);
         SERIAL_OUT_TO_CODECS <= (state == LS_RUN) ? tx_rd[~half[2:0]] : 1'b0;
      end
   end

   // ==========================================================
   // inbound lines
   logic [LINES-1:0] sdin_meta;
   logic [LINES-1:0] sdin_s;
   logic sample;
   logic [BIT_W-1:0] rx_bit;

   always_ff @(posedge LINK_CLK) begin
      sdin_meta <= SERIAL_IN_FROM_CODECS;
      sdin_s <= sdin_meta;
   end

   // the two input flops cost a whole bit, so each low phase takes the bit before it;
   // bit 0 of a frame is skipped so the last bit of the old frame never closes a word
   assign rx_bit = bit_idx - 9'h001;
   assign sample = advance && half[0] && (bit_idx != '0) && (state == LS_RUN);

   for (genvar g = 0; g < LINES; g++) begin : g_line
      logic [RX_WORD_W-1:0] shift;
      logic [RX_WORD_W-1:0] hold;
      logic hold_first;
      logic rx_toggle;
      logic tog_meta;
      logic tog_s;
      logic tog_d;
      logic valid_r;
      logic first_r;
      logic [RX_WORD_W-1:0] data_r;

      always_ff @(posedge LINK_CLK) begin
         if (lrst) begin
            shift <= '0;
            hold <= '0;
            hold_first <= 1'b0;
            rx_toggle <= 1'b0;
         end else if (sample) begin
            shift <= {shift[RX_WORD_W-2:0], sdin_s[g]};
            if (rx_bit[3:0] == RX_WORD_LAST) begin
               hold <= {shift[RX_WORD_W-2:0], sdin_s[g]};
               hold_first <= (rx_bit[BIT_W-1:4] == '0);
               rx_toggle <= ~rx_toggle;
            end
         end
      end

      // hold is stable for 16 bit clocks, far longer than the toggle takes to cross
      always_ff @(posedge CLK) begin
         if (RST) begin
            tog_meta <= 1'b0;
            tog_s <= 1'b0;
            tog_d <= 1'b0;
            valid_r <= 1'b0;
            first_r <= 1'b0;
            data_r <= '0;
         end else if (CE) begin
            tog_meta <= rx_toggle;
            tog_s <= tog_meta;
            tog_d <= tog_s;
            valid_r <= tog_s ^ tog_d;
            if (tog_s ^ tog_d) begin
               data_r <= hold;
               first_r <= hold_first;
            end
         end
      end

      assign RX_VALID[g] = valid_r;
      assign RX_FIRST[g] = first_r;
      assign RX_DATA[g*RX_WORD_W +: RX_WORD_W] = data_r;
   end

   // ==========================================================
   // frame boundary event into the system domain
   logic frame_toggle;
   logic ftog_meta;
   logic ftog_s;
   logic ftog_d;

   always_ff @(posedge LINK_CLK) begin
      if (lrst) begin
         frame_toggle <= 1'b0;
      end else if (frame_wrap && state == LS_RUN) begin
         frame_toggle <= ~frame_toggle;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         ftog_meta <= 1'b0;
         ftog_s <= 1'b0;
         ftog_d <= 1'b0;
         FRAME_TICK <= 1'b0;
      end else if (CE) begin
         ftog_meta <= frame_toggle;
         ftog_s <= ftog_meta;
         ftog_d <= ftog_s;
         FRAME_TICK <= ftog_s ^ ftog_d;
      end
   end

endmodule

// [rtl/acl_pkg.sv]
// constants, types and the frame-sync shape of the codec serial link
package acl_pkg;

   // ==========================================================
   // clocks and frame geometry
   localparam int CLK_HZ = 20_000_000;
   localparam int BIT_CLOCK_HZ = 24_000_000;
   localparam int FRAME_RATE_HZ = 48_000;
   localparam int BITS_PER_FRAME = BIT_CLOCK_HZ / FRAME_RATE_HZ;
   localparam int HALVES_PER_FRAME = 2 * BITS_PER_FRAME;
   localparam int HALF_W = 10;
   localparam int BIT_W = HALF_W - 1;
   localparam logic [HALF_W-1:0] LAST_HALF = HALF_W'(HALVES_PER_FRAME - 1);
   localparam int LINK_DIV_HALF_DEFAULT = 1;

   // ==========================================================
   // frame sync marker and stream number field
   localparam int SYNC_MARK_BITS = 4;
   localparam logic [BIT_W-1:0] SYNC_MARK_FIRST = BIT_W'(BITS_PER_FRAME - SYNC_MARK_BITS);
   localparam logic [HALF_W-1:0] MARK_DECIDE_HALF = HALF_W'(2 * (BITS_PER_FRAME - SYNC_MARK_BITS) - 1);
   localparam int TAG_W = 4;
   localparam logic [BIT_W-1:0] TAG_START_BIT = 9'h008;
   localparam logic [BIT_W-1:0] TAG_LAST_BIT = 9'h00C;
   localparam logic [TAG_W-1:0] TAG_RESET = 4'h0;

   // ==========================================================
   // data paths
   localparam int LINES = 2;
   localparam int RX_WORD_W = 16;
   localparam logic [3:0] RX_WORD_LAST = 4'hF;
   localparam int TX_BYTE_W = 8;
   localparam int TX_DEPTH = 128;
   localparam int TX_ADDR_W = 7;

   typedef enum logic [1:0] {LS_RESET, LS_IDLE, LS_RUN} acl_link_state_type;

   // level of the frame sync line for one bit-clock slot
   function automatic logic acl_sync_level(input logic [BIT_W-1:0] bit_idx, input logic [TAG_W-1:0] tag,
                                           input logic tag_on, input logic mark_on);
      logic level;
      logic [BIT_W-1:0] off;
      level = 1'b0;
      off = bit_idx - TAG_START_BIT - 9'h001;
      if (mark_on && bit_idx >= SYNC_MARK_FIRST) begin
         level = 1'b1;
      end else if (tag_on && tag != TAG_RESET) begin
         if (bit_idx == TAG_START_BIT) begin
            level = 1'b1;
         end else if (bit_idx > TAG_START_BIT && bit_idx <= TAG_LAST_BIT) begin
            level = tag[~off[1:0]];
         end
      end
      return level;
   endfunction

endpackage

// [rtl/acl_tx_ram.sv]
// outbound frame buffer: written from the system clock, read on the link clock
module acl_tx_ram #(
   parameter int WIDTH = acl_pkg::TX_BYTE_W,
   parameter int DEPTH = acl_pkg::TX_DEPTH,
   parameter int ADDR_W = acl_pkg::TX_ADDR_W
) (
   // write side
   input wire logic wr_clk,
   input wire logic wr_en,
   input wire logic [ADDR_W-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   // read side
   input wire logic rd_clk,
   input wire logic [ADDR_W-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data
);
   import acl_pkg::*;

   // ==========================================================
   // storage
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge wr_clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // a byte read while it is rewritten may mix old and new frames
   always_ff @(posedge rd_clk) begin
      rd_data <= mem[rd_addr];
   end

endmodule

// [test/acl_sva.sv]
// assertions on the pins and pulses of the codec link controller
module acl_sva #(
   parameter int LINK_DIV_HALF = 1
) (
   // clocks and reset
   input wire logic CLK,
   input wire logic RST,
   input wire logic LINK_CLK,
   // watched ports
   input wire logic CODEC_RESET_REQ,
   input wire logic CODEC_RESET_N,
   input wire logic FRAME_SYNC,
   input wire logic LINK_BIT_CLOCK,
   input wire logic FRAME_TICK,
   input wire logic [acl_pkg::LINES-1:0] RX_VALID
);
   // ======
   // helpers: settle count after reset, link cycles since the last marker
   localparam int DIV = LINK_DIV_HALF;
   localparam int FRAME_LC = 1000 * LINK_DIV_HALF;
   logic [3:0] up;
   logic [11:0] ph;
   logic sd;
   logic mk;
   // tag field rises come soon after a marker, so distance tells them apart
   assign mk = FRAME_SYNC && !sd && ph > FRAME_LC - 100;
   always_ff @(posedge LINK_CLK) begin
      sd <= FRAME_SYNC;
      up <= RST ? 4'h0 : up + {3'h0, up != 4'h8};
      ph <= RST ? 12'hFFF : mk ? 12'h000 : ph + {11'h000, ph != 12'hFFF};
   end
   // ======
   // assertions
   AST_CODEC_RESET: assert property (@(posedge CLK) disable iff (RST)
      CODEC_RESET_REQ |=> !CODEC_RESET_N) else $error("codec reset not low on request");
   AST_BIT_CLOCK_RUNS: assert property (@(posedge LINK_CLK) disable iff (RST)
      up == 4'h8 |-> ##[1:DIV] $changed(LINK_BIT_CLOCK)) else $error("bit clock stopped");
   AST_SYNC_ON_RISE: assert property (@(posedge LINK_CLK) disable iff (RST)
      up == 4'h8 && $changed(FRAME_SYNC) |-> LINK_BIT_CLOCK) else $error("sync moved off a bit start");
   AST_FRAME_PERIOD: assert property (@(posedge LINK_CLK) disable iff (RST)
      mk && ph < FRAME_LC + 100 |-> ph == FRAME_LC - 1) else $error("frame period wrong");
   // marker length written for a divider of one
   AST_MARKER_LEN: assert property (@(posedge LINK_CLK) disable iff (RST)
      mk |-> FRAME_SYNC [*8] ##1 !FRAME_SYNC) else $error("marker length wrong");
   AST_RX0_GAP: assert property (@(posedge CLK) disable iff (RST)
      RX_VALID[0] |=> !RX_VALID[0] [*6]) else $error("line 0 words too close");
   AST_RX1_GAP: assert property (@(posedge CLK) disable iff (RST)
      RX_VALID[1] |=> !RX_VALID[1] [*6]) else $error("line 1 words too close");
   AST_TICK_GAP: assert property (@(posedge CLK) disable iff (RST)
      FRAME_TICK |=> !FRAME_TICK [*8]) else $error("frame ticks too close");
   COV_MARKER: cover property (@(posedge LINK_CLK) disable iff (RST) mk);
   COV_BOTH: cover property (@(posedge CLK) disable iff (RST) RX_VALID == 2'h3);
   COV_TICK: cover property (@(posedge CLK) disable iff (RST) FRAME_TICK);
endmodule

// [test/acl_codec_model.sv]
// behavioural pair of codecs on the far side of the link
module acl_codec_model (
   // link pins
   input wire logic codec_reset_n,
   input wire logic frame_sync,
   input wire logic link_bit_clock,
   input wire logic serial_out_to_codecs,
   output logic [1:0] serial_in_from_codecs,
   // observations for the bench
   output logic [4:0] seen_field,
   output logic [15:0] seen_out
);
   timeunit 1ns;
   timeprecision 1ps;
   int b = 999;
   int hi = 0;
   logic [15:0] w;
   initial serial_in_from_codecs = 2'h0;
   initial seen_field = 5'h00;
   initial seen_out = 16'h0000;
   // ======
   // sample a little after each edge, since pins change on the same link edge
   always @(posedge link_bit_clock) begin
      #3;
      if (!frame_sync && hi >= 4 && b >= 400) b = 0;
      else if (b < 999) b++;
      hi = frame_sync ? hi + 1 : 0;
      if (b >= 8 && b <= 12) seen_field[12-b] = frame_sync;
      if (b < 8) seen_out[15-2*b] = serial_out_to_codecs;
      for (int g = 0; g < 2; g++) begin
         w = {4'hA, 3'h0, g[0], 3'h0, 5'(b / 16)};
         // pull-down wins while in reset or outside words
         serial_in_from_codecs[g] = (codec_reset_n && b < 496) ? w[15-b%16] : 1'h0;
      end
   end
   always @(negedge link_bit_clock) begin
      #3;
      if (b < 8) seen_out[14-2*b] = serial_out_to_codecs;
   end
endmodule

// [test/test_audio_codec_link.sv]
// self-checking bench of the codec link controller
module test_audio_codec_link import acl_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic CLK = 1'h0, LINK_CLK = 1'h0, RST = 1'h1, CE = 1'h1, quiet = 1'h0;
   logic RUN_ENABLE = 1'h0, CODEC_RESET_REQ = 1'h0, TAG_LOAD = 1'h0, TX_WRITE = 1'h0;
   logic [TAG_W-1:0] STREAM_TAG = 4'h0;
   logic [TX_ADDR_W-1:0] TX_ADDR = 7'h00;
   logic [TX_BYTE_W-1:0] TX_DATA = 8'h00;
   logic [LINES-1:0] RX_VALID, RX_FIRST, SERIAL_IN_FROM_CODECS;
   logic [LINES*RX_WORD_W-1:0] RX_DATA;
   logic FRAME_TICK, CODEC_RESET_N, FRAME_SYNC, LINK_BIT_CLOCK, SERIAL_OUT_TO_CODECS;
   logic [4:0] seen_field;
   logic [15:0] seen_out;
   // rows: stream number beside start bit and number seen on the sync line
   logic [8:0] rows [5] = '{{4'h1, 5'h11}, {4'h6, 5'h16}, {4'h9, 5'h19}, {4'hF, 5'h1F}, {4'h0, 5'h00}};
   int fails = 0, checked = 0, cyc = 0, n = 0;
   int k [2] = '{0, 0};
   int words [2] = '{0, 0};
   acl_controller #(.LINK_DIV_HALF(1)) acl_controller_i (.CLK, .RST, .CE, .LINK_CLK, .RUN_ENABLE,
      .CODEC_RESET_REQ, .TAG_LOAD, .STREAM_TAG, .TX_WRITE, .TX_ADDR, .TX_DATA, .RX_VALID, .RX_DATA,
      .RX_FIRST, .FRAME_TICK, .CODEC_RESET_N, .FRAME_SYNC, .LINK_BIT_CLOCK, .SERIAL_OUT_TO_CODECS,
      .SERIAL_IN_FROM_CODECS);
   acl_codec_model acl_codec_model_i (.codec_reset_n(CODEC_RESET_N), .frame_sync(FRAME_SYNC),
      .link_bit_clock(LINK_BIT_CLOCK), .serial_out_to_codecs(SERIAL_OUT_TO_CODECS),
      .serial_in_from_codecs(SERIAL_IN_FROM_CODECS), .seen_field(seen_field), .seen_out(seen_out));
   // ======
   // clocks, timeout and helpers
   initial forever #25 CLK = ~CLK;
   initial begin
      #5;
      forever #6 LINK_CLK = ~LINK_CLK;
   end
   task automatic summarize();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic step(input int c);
      repeat (c) @(posedge CLK);
      #2;
   endtask
   // n ends at 1000 when no tick came
   task automatic tick_gap();
      n = 0;
      do begin
         @(posedge CLK);
         #2;
         n++;
      end while (FRAME_TICK !== 1'h1 && n < 1000);
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      TX_WRITE = 1'h1;
      TX_ADDR = a;
      TX_DATA = d;
      step(1);
   endtask
   always @(posedge CLK) begin
      cyc++;
      if (cyc == 15000) begin
         fails++;
         summarize();
      end
   end
   // inbound words; cut frames under reset are not judged
   always @(posedge CLK) begin
      #1;
      for (int g = 0; g < 2; g++) begin
         if (RX_VALID[g] === 1'h1) begin
            k[g] = (RX_FIRST[g] === 1'h1) ? 0 : k[g] + 1;
            words[g]++;
            if (!quiet) chk(RX_DATA[16*g+:16], {4'hA, 3'h0, g[0], 3'h0, 5'(k[g])});
         end
      end
   end
   // ======
   // main sequence
   initial begin
      step(20);
      chk(CODEC_RESET_N, 1'h0);
      chk({RX_VALID, RX_FIRST, FRAME_TICK}, 5'h00);
      chk($bits(SERIAL_IN_FROM_CODECS), 2);
      RST = 1'h0;
      wr(7'h00, 8'hC5);
      wr(7'h01, 8'h3A);
      TX_WRITE = 1'h0;
      RUN_ENABLE = 1'h1;
      foreach (rows[i]) begin
         STREAM_TAG = rows[i][8:5];
         TAG_LOAD = 1'h1;
         step(1);
         TAG_LOAD = 1'h0;
         step(750);
         chk(seen_field, rows[i][4:0]);
         chk(seen_out, 16'hC53A);
      end
      tick_gap();
      tick_gap();
      chk(n >= 239 && n <= 241, 1);
      quiet = 1'h1;
      CODEC_RESET_REQ = 1'h1;
      step(2);
      chk(CODEC_RESET_N, 1'h0);
      step(300);
      tick_gap();
      chk(n, 1000);
      CODEC_RESET_REQ = 1'h0;
      tick_gap();
      chk(n < 1000, 1);
      RST = 1'h1;
      step(20);
      chk({CODEC_RESET_N, RX_VALID, FRAME_TICK}, 4'h0);
      RST = 1'h0;
      tick_gap();
      tick_gap();
      quiet = 1'h0;
      step(500);
      chk(words[0] > 100 && words[1] > 100, 1);
      summarize();
   end
endmodule
bind acl_controller acl_sva #(.LINK_DIV_HALF(LINK_DIV_HALF)) acl_sva_i (.CLK, .RST, .LINK_CLK,
   .CODEC_RESET_REQ, .CODEC_RESET_N, .FRAME_SYNC, .LINK_BIT_CLOCK, .FRAME_TICK, .RX_VALID);
